// *** shared/pecr_params.svh ***
// Constants for the extended control register bank
// What this block does
// - Node/repeater bit, strap reset, zero means node
// - Speed from control bit or hardware pin
// - Two-bit bank select picks register map
// - Crossover enable resets one, pair mode zero
// - Float bit tri-states twisted-pair line outputs
// - Auto 100M power-down enabled by default
// - Drive enhance bit raises output strength
`ifndef PECR_PARAMS_SVH
`define PECR_PARAMS_SVH
`define PECR_ADDR_CTRL_A    5'h13
`define PECR_ADDR_CTRL_B    5'h14
`define PECR_BANK_LEGACY    2'h1
`define PECR_A_NODE         15
`define PECR_A_SPDSEL       14
`define PECR_A_RFAULT       13
`define PECR_A_BANK_HI      12
`define PECR_A_BANK_LO      11
`define PECR_A_XOVER        9
`define PECR_A_PAIR         8
`define PECR_A_FLOAT        7
`define PECR_A_AUTOPD       0
`define PECR_B_DRIVE        15
`define PECR_A_RW_MASK      16'hdbff
`define PECR_A_RESET        16'h0201
`define PECR_B_RESET        16'h3fe9
`define PECR_PRE_ONES       5'h1f
`define PECR_OP_READ        2'h2
`define PECR_OP_WRITE       2'h1
`define PECR_LEN_OP         5'h01
`define PECR_LEN_ADDR       5'h04
`define PECR_LEN_TA         5'h01
`define PECR_LEN_DATA       5'h0f
`endif

// *** shared/pecr_pkg.sv ***
// Types for the extended control register bank
package pecr_pkg;
   typedef enum logic [2:0] {
      PECR_PRE, PECR_ST, PECR_OP, PECR_PHY, PECR_REG, PECR_TA, PECR_DAT
   } pecr_state_t;

   typedef struct packed {
      logic       node_repeater;          // 0 node, 1 repeater
      logic       speed_100;              // Effective speed choice
      logic [1:0] bank;                   // Register map selector
      logic       auto_crossover_enable;  // Automatic crossover
      logic       manual_pair_assignment; // Manual pair mode
      logic       line_output_float;      // Tri-state line outputs
      logic       auto_pd_100;            // Auto 100M power-down
      logic       drive_enhance;          // 1.8V output strength up
   } pecr_ctrl_t;
endpackage : pecr_pkg

// *** rtl/pecr_regs.sv ***
// Extended control registers behind the serial management port
`timescale 1ns/1ns
`default_nettype none
`include "pecr_params.svh"
module pecr_regs (
   input  wire logic              clk_in,          // 20 MHz clock
   input  wire logic              srst_in,         // Sync reset, high
   input  wire logic              ce_in,           // Clock enable
   input  wire logic              mdc_in,          // Management clock pin
   input  wire logic              mdio_in,         // Management data in
   output logic                   mdio_out,        // Management data out
   output logic                   mdio_oe_out,     // High while driving
   input  wire logic [4:0]        phy_addr_in,     // Own station address
   input  wire logic              strap_repeater_in, // Node/repeater strap
   input  wire logic              strap_hw_speed_in, // Speed select strap
   input  wire logic              speed_pin_in,    // Hardware speed pin
   input  wire logic              ctrl_speed_in,   // Basic control speed
   input  wire logic              remote_fault_in, // Remote fault state
   output pecr_pkg::pecr_ctrl_t   ctrl_out         // Control outputs
);
   import pecr_pkg::*;

   // Pin synchronisers
   logic [1:0] mdc_s, mdio_s, rep_s, hws_s, spd_s;
   logic       mdc_prev;
   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         mdc_s  <= {mdc_s[0], mdc_in};
         mdio_s <= {mdio_s[0], mdio_in};
         rep_s  <= {rep_s[0], strap_repeater_in};
         hws_s  <= {hws_s[0], strap_hw_speed_in};
         spd_s  <= {spd_s[0], speed_pin_in};
         mdc_prev <= mdc_s[1];
      end
   end

   wire mdc_rise = ce_in & mdc_s[1] & ~mdc_prev;
   wire bit_in   = mdio_s[1];

   // Register storage
   logic [15:0] reg_a_q, reg_b_q;
   wire  [1:0]  bank = {reg_a_q[`PECR_A_BANK_HI], reg_a_q[`PECR_A_BANK_LO]};

   // Address decode, shared by read and write paths
   function automatic logic hit_b(input logic [4:0] a, input logic [1:0] b);
      hit_b = (a == `PECR_ADDR_CTRL_B) && (b != `PECR_BANK_LEGACY);
   endfunction

   // Frame receiver state
   pecr_state_t st_q;
   logic [4:0]  cnt_q;
   logic [15:0] sh_q, rd_q;
   logic [1:0]  op_q;
   logic        me_q;
   logic [4:0]  ra_q;
   logic        wr_stb;
   logic [15:0] wr_data;

   wire  [4:0]  reg_addr = {sh_q[3:0], bit_in};
   wire  [15:0] rd_a = (reg_a_q & `PECR_A_RW_MASK)
                     | (16'(remote_fault_in) << `PECR_A_RFAULT);
   wire  [15:0] rd_sel = (reg_addr == `PECR_ADDR_CTRL_A) ? rd_a :
                         hit_b(reg_addr, bank) ? reg_b_q : 16'h0000;
   wire         cnt_end = (st_q == PECR_OP   && cnt_q == `PECR_LEN_OP)
                       || (st_q == PECR_PHY  && cnt_q == `PECR_LEN_ADDR)
                       || (st_q == PECR_REG  && cnt_q == `PECR_LEN_ADDR)
                       || (st_q == PECR_TA   && cnt_q == `PECR_LEN_TA)
                       || (st_q == PECR_DAT  && cnt_q == `PECR_LEN_DATA);

   // Frame sequencing on each management clock rise
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_q <= PECR_PRE;
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         rd_q <= 16'h0000;
         op_q <= 2'h0;
         me_q <= 1'b0;
         ra_q <= 5'h00;
         mdio_out <= 1'b0;
         mdio_oe_out <= 1'b0;
      end else if (mdc_rise) begin
         sh_q <= {sh_q[14:0], bit_in};
         cnt_q <= cnt_end ? 5'h00 : cnt_q + 5'h01;
         case (st_q)
            PECR_PRE: begin
               if (!bit_in) begin
                  cnt_q <= 5'h00;
                  if (cnt_q == `PECR_PRE_ONES) st_q <= PECR_ST;
               end else if (cnt_q == `PECR_PRE_ONES) begin
                  cnt_q <= cnt_q;
               end
            end
            PECR_ST: begin
               cnt_q <= 5'h00; // Op field counts from zero
               st_q  <= bit_in ? PECR_OP : PECR_PRE;
            end
            PECR_OP: if (cnt_end) begin
               op_q <= {sh_q[0], bit_in};
               st_q <= PECR_PHY;
            end
            PECR_PHY: if (cnt_end) begin
               me_q <= (reg_addr == phy_addr_in);
               st_q <= PECR_REG;
            end
            PECR_REG: if (cnt_end) begin
               ra_q <= reg_addr;
               rd_q <= rd_sel;
               st_q <= PECR_TA;
            end
            PECR_TA: begin
               if (me_q && op_q == `PECR_OP_READ) begin
                  mdio_oe_out <= 1'b1;
                  mdio_out <= cnt_end ? rd_q[15] : 1'b0;
                  if (cnt_end) rd_q <= {rd_q[14:0], 1'b0};
               end
               if (cnt_end) st_q <= PECR_DAT;
            end
            PECR_DAT: begin
               mdio_out <= rd_q[15];
               rd_q <= {rd_q[14:0], 1'b0};
               if (cnt_end) begin
                  mdio_oe_out <= 1'b0;
                  mdio_out <= 1'b0;
                  st_q <= PECR_PRE;
               end
            end
            default: st_q <= PECR_PRE;
         endcase
      end
   end

   // Data pin driven only while answering an addressed read
   read_drive_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      mdio_oe_out |-> me_q && op_q == `PECR_OP_READ
                   && (st_q == PECR_TA || st_q == PECR_DAT))
      else $error("data pin driven outside a read");

   // Write strobe at the last data bit of an addressed write
   assign wr_stb  = mdc_rise && st_q == PECR_DAT && cnt_end && me_q
                 && op_q == `PECR_OP_WRITE;
   assign wr_data = {sh_q[14:0], bit_in};

   // Register file, straps caught while reset is held
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         reg_a_q <= `PECR_A_RESET;
         reg_a_q[`PECR_A_NODE]   <= rep_s[1];
         reg_a_q[`PECR_A_SPDSEL] <= hws_s[1];
         reg_b_q <= `PECR_B_RESET;
      end else if (wr_stb) begin
         if (ra_q == `PECR_ADDR_CTRL_A)
            reg_a_q <= wr_data & `PECR_A_RW_MASK;
         if (hit_b(ra_q, bank))
            reg_b_q <= wr_data;
      end
   end

   // Written bits reach the control outputs one clock later
   node_write_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      wr_stb && ra_q == `PECR_ADDR_CTRL_A |=>
      ctrl_out.node_repeater == $past(wr_data[`PECR_A_NODE]))
      else $error("node bit not written");
   xover_write_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      wr_stb && ra_q == `PECR_ADDR_CTRL_A |=>
      ctrl_out.auto_crossover_enable == $past(wr_data[`PECR_A_XOVER])
      && ctrl_out.manual_pair_assignment == $past(wr_data[`PECR_A_PAIR]))
      else $error("crossover bits not written");
   autopd_write_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      wr_stb && ra_q == `PECR_ADDR_CTRL_A |=>
      ctrl_out.auto_pd_100 == $past(wr_data[`PECR_A_AUTOPD]))
      else $error("power-down bit not written");
   drive_write_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      wr_stb && hit_b(ra_q, bank) |=>
      ctrl_out.drive_enhance == $past(wr_data[`PECR_B_DRIVE]))
      else $error("drive enhance bit not written");

   // Speed choice between control bit and pin
   logic speed_q;
   always_ff @(posedge clk_in) begin
      if (srst_in) speed_q <= 1'b0;
      else if (ce_in)
         speed_q <= reg_a_q[`PECR_A_SPDSEL] ? spd_s[1] : ctrl_speed_in;
   end

   // Low enable holds every register in place
   freeze_hold_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      !ce_in |=> $stable(speed_q) && $stable(st_q) && $stable(reg_a_q)
               && $stable(reg_b_q) && $stable(mdio_oe_out))
      else $error("state moved while enable low");

   // Control outputs straight from register bits, speed from the speed_q flop
   assign ctrl_out.node_repeater          = reg_a_q[`PECR_A_NODE];
   assign ctrl_out.speed_100              = speed_q;
   assign ctrl_out.bank                   = bank;
   assign ctrl_out.auto_crossover_enable  = reg_a_q[`PECR_A_XOVER];
   assign ctrl_out.manual_pair_assignment = reg_a_q[`PECR_A_PAIR];
   assign ctrl_out.line_output_float      = reg_a_q[`PECR_A_FLOAT];
   assign ctrl_out.auto_pd_100            = reg_a_q[`PECR_A_AUTOPD];
   assign ctrl_out.drive_enhance          = reg_b_q[`PECR_B_DRIVE];

   // Checks
   node_strap_a: assert property (@(posedge clk_in)
      srst_in ##1 !srst_in |-> ctrl_out.node_repeater == $past(rep_s[1]))
      else $error("node bit did not take strap");
   speed_mux_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      ce_in && $past(ce_in) && !$past(srst_in) |->
      speed_q == $past(reg_a_q[`PECR_A_SPDSEL] ? spd_s[1] : ctrl_speed_in))
      else $error("speed source wrong");
   bank_block_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      wr_stb && ra_q == `PECR_ADDR_CTRL_B && bank == `PECR_BANK_LEGACY
      |=> $stable(reg_b_q)) else $error("legacy bank wrote reg b");
   xover_reset_a: assert property (@(posedge clk_in)
      srst_in |=> ctrl_out.auto_crossover_enable
              && !ctrl_out.manual_pair_assignment)
      else $error("crossover bits reset wrong");
   float_write_a: assert property (@(posedge clk_in)
      disable iff (srst_in)
      wr_stb && ra_q == `PECR_ADDR_CTRL_A |=>
      ctrl_out.line_output_float == $past(wr_data[`PECR_A_FLOAT]))
      else $error("float bit not written");
   autopd_reset_a: assert property (@(posedge clk_in)
      srst_in ##1 !srst_in |->
      ctrl_out.auto_pd_100 && !ctrl_out.line_output_float)
      else $error("power-down or float reset wrong");
   drive_reset_a: assert property (@(posedge clk_in)
      srst_in |=> !ctrl_out.drive_enhance && reg_b_q == `PECR_B_RESET)
      else $error("drive enhance reset wrong");
endmodule : pecr_regs
`default_nettype wire

// *** tb/pecr_mgr.sv ***
// Station manager model that sends serial management frames
`timescale 1ns/1ns
`default_nettype none
`include "pecr_params.svh"
module pecr_mgr (
   input  wire logic clk_in,  // Bench clock
   input  wire logic line_in, // Resolved data line
   output logic      mdc_out, // Management clock, still between frames
   output logic      drv_out, // High while the manager drives the line
   output logic      val_out  // Level the manager drives
);
   // Idle manager at time zero
   initial begin
      mdc_out = 1'b0;
      drv_out = 1'b0;
      val_out = 1'b0;
   end
   // Whole frame, half period five clocks, read bits taken at mdc rise
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic [63:0] bits;
      bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_in);
         mdc_out = 1'b0;
         drv_out = (op == `PECR_OP_WRITE) || (i < 46); // Release for reads
         val_out = bits[63-i];
         repeat (5) @(negedge clk_in);
         if (i >= 48) rd = {rd[14:0], line_in};
         mdc_out = 1'b1;
         repeat (4) @(negedge clk_in);
      end
      @(negedge clk_in);
      mdc_out = 1'b0;
      drv_out = 1'b0;
      repeat (8) @(negedge clk_in);
   endtask : frame
endmodule : pecr_mgr
`default_nettype wire

// *** tb/pecr_regs_tb.sv ***
// Self-checking bench for the extended control register bank
`timescale 1ns/1ns
`default_nettype none
`include "pecr_params.svh"
module pecr_regs_tb;
   import pecr_pkg::*;
   localparam logic [4:0] PHY = 5'h05;
   localparam logic [1:0] RD = `PECR_OP_READ;
   localparam logic [1:0] WR = `PECR_OP_WRITE;
   localparam logic [4:0] RA = `PECR_ADDR_CTRL_A;
   localparam logic [4:0] RB = `PECR_ADDR_CTRL_B;
   logic clk_in = 1'b0, srst_in = 1'b1, speed_pin = 1'b0, csp = 1'b0;
   logic ce = 1'b1, strap_rep = 1'b0, strap_hws = 1'b1;
   logic rfault = 1'b0, mdc, mdio_out, mdio_oe, drv, val;
   wire  mdio_in;
   pecr_ctrl_t ctrl;
   int err_total = 0, cmp_count = 0;
   // Pulled-up data line
   assign mdio_in = mdio_oe ? mdio_out : (drv ? val : 1'b1);
   always #25 clk_in = ~clk_in;
   pecr_mgr u_mgr (.clk_in(clk_in), .line_in(mdio_in), .mdc_out(mdc),
                   .drv_out(drv), .val_out(val));
   pecr_regs u_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
      .mdc_in(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_out(mdio_oe), .phy_addr_in(PHY),
      .strap_repeater_in(strap_rep),
      .strap_hw_speed_in(strap_hws), .speed_pin_in(speed_pin),
      .ctrl_speed_in(csp), .remote_fault_in(rfault), .ctrl_out(ctrl));
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk1
   // One frame; reads compared with the expected word
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] got;
      u_mgr.frame(op, phy, ra, d, got);
      if (op == RD) chk16(got, d);
      chk1(mdio_oe, 1'b0);
   endtask : xfer
   task automatic t_reset();
      xfer(RD, PHY, RA, 16'h4201);
      xfer(RD, PHY, RB, `PECR_B_RESET);
      chk1(ctrl.node_repeater, 1'b0);
      chk1(ctrl.auto_crossover_enable, 1'b1);
      chk1(ctrl.manual_pair_assignment, 1'b0);
      chk1(ctrl.line_output_float, 1'b0);
      chk1(ctrl.auto_pd_100, 1'b1);
      chk1(ctrl.drive_enhance, 1'b0);
      chk16({14'h0000, ctrl.bank}, 16'h0000);
   endtask : t_reset
   // Speed follows csp or the pin as selected
   task automatic t_speed(input logic hw);
      csp = ~hw;
      speed_pin = hw;
      repeat (6) @(negedge clk_in);
      chk1(ctrl.speed_100, 1'b1);
      csp = hw;
      speed_pin = ~hw;
      repeat (6) @(negedge clk_in);
      chk1(ctrl.speed_100, 1'b0);
   endtask : t_speed
   task automatic t_write_a();
      rfault = 1'b1;
      xfer(WR, PHY, RA, 16'h2580);
      xfer(RD, PHY, RA, 16'h2180);
      chk1(ctrl.auto_crossover_enable, 1'b0);
      chk1(ctrl.manual_pair_assignment, 1'b1);
      chk1(ctrl.line_output_float, 1'b1);
      chk1(ctrl.auto_pd_100, 1'b0);
      t_speed(1'b0);
   endtask : t_write_a
   task automatic t_bank();
      xfer(WR, PHY, RA, 16'h0980);
      chk16({14'h0000, ctrl.bank}, 16'h0001);
      xfer(RD, PHY, RB, 16'h0000);
      xfer(WR, PHY, RB, 16'hbfe9);
      chk1(ctrl.drive_enhance, 1'b0);
      xfer(WR, PHY, RA, 16'h1180);
      xfer(RD, PHY, RB, `PECR_B_RESET);
      xfer(WR, PHY, RB, 16'hbfe9);
      chk1(ctrl.drive_enhance, 1'b1);
      xfer(RD, PHY, RB, 16'hbfe9);
   endtask : t_bank
   // Frames for another station leave the bank alone
   task automatic t_refuse();
      xfer(RD, PHY ^ 5'h01, RA, 16'hffff);
      xfer(WR, PHY ^ 5'h01, RA, 16'h0000);
      xfer(RD, PHY, RA, 16'h3180);
   endtask : t_refuse
   // Mid-run reset with straps turned over, then enable freeze
   task automatic t_restrap();
      strap_rep = 1'b1;
      strap_hws = 1'b0;
      srst_in = 1'b1;
      repeat (4) @(negedge clk_in);
      srst_in = 1'b0;
      @(negedge clk_in);
      chk1(ctrl.node_repeater, 1'b1);
      chk1(ctrl.drive_enhance, 1'b0);
      chk16({14'h0000, ctrl.bank}, 16'h0000);
      xfer(RD, PHY, RA, 16'ha201);
      xfer(WR, PHY, RA, 16'h0201);
      chk1(ctrl.node_repeater, 1'b0);
      csp = 1'b1;
      repeat (6) @(negedge clk_in);
      chk1(ctrl.speed_100, 1'b1);
      ce = 1'b0;
      csp = 1'b0;
      repeat (6) @(negedge clk_in);
      chk1(ctrl.speed_100, 1'b1);
      ce = 1'b1;
      repeat (6) @(negedge clk_in);
      chk1(ctrl.speed_100, 1'b0);
   endtask : t_restrap
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial begin
      repeat (4) @(negedge clk_in);
      srst_in = 1'b0;
      @(negedge clk_in);
      t_reset();
      t_speed(1'b1);
      t_write_a();
      t_bank();
      t_refuse();
      t_restrap();
      test_done();
   end
endmodule : pecr_regs_tb
`default_nettype wire
